// ---- hw/psc_pkg.sv ----
// Constants, codes and types shared by the programmable stage comparator.
package psc_pkg;
	// ==========================================================================
	// Timing base.
	localparam int unsigned CLK_PERIOD_NS     = 100;
	localparam int unsigned PROG_CYCLE_US     = 1000;
	localparam int unsigned PROG_CYCLE_CLKS   = PROG_CYCLE_US * 1000 / CLK_PERIOD_NS;
	localparam int unsigned DELTA_WIN_MS      = 20;
	localparam int unsigned DELTA_WIN_CYCLES  = DELTA_WIN_MS * 1000 / PROG_CYCLE_US;
	localparam int unsigned DELAY_STEP_US     = 5000;
	localparam int unsigned DELAY_STEP_CYCLES = DELAY_STEP_US / PROG_CYCLE_US;
	localparam int unsigned LOG_DEPTH         = 12;

	// ==========================================================================
	// Fixed-point scales: settings carry four decimals, hysteresis is in 0.0001 %.
	localparam logic signed [63:0] HYST_DEN  = 64'sh0000_0000_000f_4240;
	localparam logic signed [63:0] REL_SCALE = 64'sh0000_0000_000f_4240;
	localparam logic signed [63:0] RATIO_MUL = 64'sh0000_0000_0000_03e8;

	// ==========================================================================
	// Values after reset.
	localparam logic [2:0]  MODE_RST     = 3'h0;
	localparam logic [31:0] PICKUP_RST   = 32'h0000_0064;
	localparam logic [31:0] HYST_RST     = 32'h0000_7530;
	localparam logic [31:0] OP_STEPS_RST = 32'h0000_0008;
	localparam logic [31:0] RL_STEPS_RST = 32'h0000_000c;
	localparam logic [5:0]  EVT_MASK_RST = 6'h3f;

	// ==========================================================================
	// Register byte offsets and control field positions.
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_PICKUP   = 8'h04;
	localparam logic [7:0] OFS_HYST     = 8'h08;
	localparam logic [7:0] OFS_OP_STEPS = 8'h0c;
	localparam logic [7:0] OFS_RL_STEPS = 8'h10;
	localparam logic [7:0] OFS_BLK_LIM  = 8'h14;
	localparam logic [7:0] OFS_STATUS   = 8'h18;
	localparam logic [7:0] OFS_REMAIN   = 8'h1c;
	localparam logic [7:0] OFS_LOG_SEL  = 8'h20;
	localparam logic [7:0] OFS_LOG_TSLO = 8'h24;
	localparam logic [7:0] OFS_LOG_TSHI = 8'h28;
	localparam logic [7:0] OFS_LOG_INFO = 8'h2c;
	localparam logic [7:0] OFS_LOG_VAL  = 8'h30;
	localparam logic [7:0] OFS_LOG_RAT  = 8'h34;
	localparam logic [7:0] OFS_LOG_REM  = 8'h38;
	localparam int unsigned CTRL_BLK_EN  = 3;
	localparam int unsigned CTRL_MASK_LO = 4;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================================
	// Comparator modes, stage status and event codes.
	typedef enum logic [2:0] {
		MODE_OVER = 3'h0, MODE_OVER_ABS = 3'h1, MODE_UNDER = 3'h2, MODE_UNDER_ABS = 3'h3,
		MODE_DREL = 3'h4, MODE_DREL_ABS = 3'h5, MODE_DVAL = 3'h6, MODE_DVAL_ABS = 3'h7
	} psc_mode_e;
	typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_START = 2'h1, ST_TRIP = 2'h3, ST_BLOCK = 2'h2} psc_state_e;
	localparam logic [1:0] STAT_NORMAL  = 2'h0;
	localparam logic [1:0] STAT_STARTED = 2'h1;
	localparam logic [1:0] STAT_TRIPPED = 2'h2;
	localparam logic [1:0] STAT_BLOCKED = 2'h3;
	localparam logic [2:0] EVT_START_ON = 3'h0;
	localparam logic [2:0] EVT_TRIP_ON  = 3'h2;
	localparam logic [2:0] EVT_BLOCK_ON = 3'h4;

	typedef struct packed {
		logic [63:0] stamp;
		logic [2:0]  code;
		logic [2:0]  group;
		logic [31:0] value;
		logic [31:0] ratio;
		logic [31:0] remain;
	} psc_rec_s;
endpackage

// ---- hw/psc_stage.sv ----
// Programmable protection stage: comparator, timers, blocking, events, log and register slave.
`timescale 1ns/10ps

// Notes on behaviour
// - Mode 0: signed value above pick-up.
// - Mode 1: absolute value above pick-up.
// - Mode 2: below pick-up, optional blocking limit.
// - Mode 3: absolute below pick-up, optional blocking limit.
// - Mode 4: signed relative 20 ms change exceeds.
// - Mode 5: relative 20 ms change, either direction.
// - Mode 6: signed 20 ms change exceeds pick-up.
// - Mode 7: 20 ms change, either direction.
// - Signed pick-up level with own hysteresis.
// - Separate operate and release delay timers.
// - Blocking input sampled each program cycle start.
// - Pick-up unblocked raises START, operate countdown.
// - Pick-up while blocked raises BLOCKED, no timing.
// - Blocking ends START, release processing follows.
// - Blocking gives notification and stamped event.
// - Events on changes, ON/OFF mask each.
// - Events carry timestamp and process data.
// - Twelve-entry circular log of ON events.
// - Record: time, event, value, ratio, remaining, group.
// - Status: 0 normal, 1 started, 2 tripped, 3 blocked.
// - Delays in 5 ms steps, 40/60 ms default.
// - Hysteresis relative to pick-up magnitude.
module psc_stage
	import psc_pkg::*;
#(
	parameter int unsigned PROG_CLKS = PROG_CYCLE_CLKS,
	parameter int unsigned ADDR_W    = 8
) (
	input  wire logic               clk,
	input  wire logic               reset_n,
	input  wire logic signed [31:0] meas_value,
	input  wire logic               block_in,
	input  wire logic [2:0]         setting_group,
	input  wire logic [63:0]        rtc_time,
	input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	output logic [1:0]              s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	input  wire logic [ADDR_W-1:0]  s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	output logic [31:0]             s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready,
	output logic                    stage_start,
	output logic                    stage_trip,
	output logic                    stage_blocked,
	output logic [1:0]              stage_status,
	output logic                    evt_valid,
	output logic [2:0]              evt_code,
	output logic [63:0]             evt_time,
	output logic [31:0]             evt_value,
	output logic [31:0]             evt_ratio,
	output logic [2:0]              evt_fault_mode,
	output logic                    hmi_block_note
);
	// ==========================================================================
	// Parameter checks.
	if (PROG_CLKS < 2) begin : g_chk_clks
		$error("PROG_CLKS must be at least 2");
	end
	if (ADDR_W < 6 || ADDR_W > 32) begin : g_chk_addr
		$error("ADDR_W must lie between 6 and 32");
	end

	function automatic logic signed [63:0] abs64(input logic signed [63:0] x);
		return (x < 0) ? -x : x;
	endfunction

	function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic wr_mapped(input logic [7:0] a);
		return a == OFS_CTRL || a == OFS_PICKUP || a == OFS_HYST || a == OFS_OP_STEPS ||
			a == OFS_RL_STEPS || a == OFS_BLK_LIM || a == OFS_LOG_SEL;
	endfunction

	// ==========================================================================
	// Registers and state.
	logic [31:0]        ctrl;
	logic signed [31:0] pickup;
	logic [31:0]        hyst;
	logic [31:0]        op_steps;
	logic [31:0]        rl_steps;
	logic signed [31:0] blk_lim;
	logic [3:0]         log_sel;
	logic [31:0]        div_cnt;
	logic               tick;
	logic               eval;
	logic signed [31:0] meas_s;
	logic               blk_s;
	logic signed [31:0] hist [DELTA_WIN_CYCLES];
	logic [4:0]         hist_cnt;
	logic               picked;
	logic               pu;
	psc_state_e         state;
	psc_state_e         next_state;
	logic [31:0]        op_cnt;
	logic [31:0]        next_op_cnt;
	logic [31:0]        rl_cnt;
	logic [31:0]        next_rl_cnt;
	logic [31:0]        op_lim;
	logic [31:0]        rl_lim;
	logic               start_q;
	logic               trip_q;
	logic               blk_q;
	logic [5:0]         pend;
	logic [5:0]         new_ev;
	logic [2:0]         emit_code;
	logic               log_we;
	logic [2:0]         log_code;
	psc_rec_s           log_mem [LOG_DEPTH];
	logic [3:0]         log_wp;
	logic [3:0]         log_cnt;
	logic [31:0]        ratio;
	logic [31:0]        remain;
	logic [7:0]         wa;
	logic [7:0]         ra;
	psc_mode_e          mode;
	logic [31:0]        ctrl_wr;

	assign mode   = psc_mode_e'(ctrl[2:0]);
	// Byte-merged control word; only its low ten bits are kept by the register.
	assign ctrl_wr = merge_strb(ctrl, s_axi_wdata, s_axi_wstrb);
	assign wa     = 8'(s_axi_awaddr);
	assign ra     = 8'(s_axi_araddr);
	assign op_lim = 32'(op_steps * DELAY_STEP_CYCLES);
	assign rl_lim = 32'(rl_steps * DELAY_STEP_CYCLES);
	assign remain = (state == ST_START && op_lim > op_cnt) ? op_lim - op_cnt : 32'h0;

	// ==========================================================================
	// Program cycle divider; the evaluation strobe trails the sampling strobe by one clock.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			div_cnt <= 32'h0;
			tick    <= 1'b0;
			eval    <= 1'b0;
		end else begin
			tick <= (div_cnt == 32'(PROG_CLKS - 1));
			eval <= tick;
			if (div_cnt == 32'(PROG_CLKS - 1)) begin
				div_cnt <= 32'h0;
			end else begin
				div_cnt <= div_cnt + 32'h1;
			end
		end
	end

	// Sampling at the start of each program cycle, so one cycle sees one coherent input set.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meas_s   <= 32'sh0;
			blk_s    <= 1'b0;
			hist_cnt <= 5'h0;
			for (int i = 0; i < DELTA_WIN_CYCLES; i++) begin
				hist[i] <= 32'sh0;
			end
		end else if (tick) begin
			meas_s  <= meas_value;
			blk_s   <= block_in;
			hist[0] <= meas_s;
			for (int i = 1; i < DELTA_WIN_CYCLES; i++) begin
				hist[i] <= hist[i-1];
			end
			if (hist_cnt != 5'(DELTA_WIN_CYCLES + 1)) begin
				hist_cnt <= hist_cnt + 5'h1;
			end
		end
	end

	// ==========================================================================
	// Comparator; once picked up, the threshold moves by a fraction of the pick-up magnitude.
	always_comb begin
		logic signed [63:0] v;
		logic signed [63:0] p;
		logic signed [63:0] h;
		logic signed [63:0] d;
		logic signed [63:0] sc;
		logic               rel;
		logic               full;
		v    = 64'(meas_s);
		p    = 64'(pickup);
		h    = picked ? abs64(p) * $signed({32'h0, hyst}) / HYST_DEN : 64'sh0;
		d    = v - 64'(hist[DELTA_WIN_CYCLES-1]);
		rel  = (mode == MODE_DREL || mode == MODE_DREL_ABS);
		sc   = rel ? abs64(64'(hist[DELTA_WIN_CYCLES-1])) : 64'sh1;
		d    = rel ? d * REL_SCALE : d;
		full = (hist_cnt == 5'(DELTA_WIN_CYCLES + 1)); // The oldest slot must hold a real sample, not the reset value.
		pu   = 1'b0;
		unique case (mode)
			MODE_OVER:      pu = v > p - h;
			MODE_OVER_ABS:  pu = abs64(v) > p - h;
			MODE_UNDER:     pu = !(ctrl[CTRL_BLK_EN] && meas_s < blk_lim) && v < p + h;
			MODE_UNDER_ABS: pu = !(ctrl[CTRL_BLK_EN] && meas_s < blk_lim) && abs64(v) < p + h;
			MODE_DREL, MODE_DVAL: begin
				// Direction follows the sign of the pick-up level.
				if (p >= 0) begin
					pu = full && d > (p - h) * sc;
				end else begin
					pu = full && d < (p + h) * sc;
				end
			end
			MODE_DREL_ABS, MODE_DVAL_ABS: pu = full && abs64(d) > (abs64(p) - h) * sc;
		endcase
	end

	// Ratio of measurement to pick-up in thousandths; a zero pick-up reads as zero.
	always_comb begin
		logic signed [63:0] q;
		q     = (pickup == 32'sh0) ? 64'sh0 : 64'(meas_s) * RATIO_MUL / 64'(pickup);
		ratio = q[31:0];
	end

	// ==========================================================================
	// Stage sequence: blocking is honoured before any timing is done.
	always_comb begin
		next_state  = state;
		next_op_cnt = op_cnt;
		next_rl_cnt = rl_cnt;
		unique case (state)
			ST_IDLE: begin
				next_op_cnt = 32'h0;
				next_rl_cnt = 32'h0;
				if (pu && blk_s) begin
					next_state = ST_BLOCK;
				end else if (pu) begin
					next_state = ST_START;
				end
			end
			ST_START, ST_TRIP: begin
				if (!pu || blk_s) begin
					// Pick-up lost or blocking arrived: the release delay decides the end.
					next_rl_cnt = rl_cnt + 32'h1;
					if (next_rl_cnt >= rl_lim) begin
						next_state  = (pu && blk_s) ? ST_BLOCK : ST_IDLE;
						next_op_cnt = 32'h0;
						next_rl_cnt = 32'h0;
					end
				end else begin
					next_rl_cnt = 32'h0;
					if (state == ST_START) begin
						next_op_cnt = op_cnt + 32'h1;
						if (next_op_cnt >= op_lim) begin
							next_state = ST_TRIP;
						end
					end
				end
			end
			ST_BLOCK: begin
				if (!(pu && blk_s)) begin
					next_state = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state         <= ST_IDLE;
			op_cnt        <= 32'h0;
			rl_cnt        <= 32'h0;
			picked        <= 1'b0;
			stage_start   <= 1'b0;
			stage_trip    <= 1'b0;
			stage_blocked <= 1'b0;
			stage_status  <= STAT_NORMAL;
		end else if (eval) begin
			state         <= next_state;
			op_cnt        <= next_op_cnt;
			rl_cnt        <= next_rl_cnt;
			picked        <= pu;
			stage_start   <= (next_state == ST_START || next_state == ST_TRIP) && pu && !blk_s;
			stage_trip    <= next_state == ST_TRIP;
			stage_blocked <= next_state == ST_BLOCK || (pu && blk_s);
			if (next_state == ST_BLOCK || (pu && blk_s)) begin
				stage_status <= STAT_BLOCKED;
			end else if (next_state == ST_TRIP) begin
				stage_status <= STAT_TRIPPED;
			end else if (next_state == ST_START && pu) begin
				stage_status <= STAT_STARTED;
			end else begin
				stage_status <= STAT_NORMAL;
			end
		end
	end

	// ==========================================================================
	// Event detection; coincident events queue as pending bits and leave one per clock.
	assign new_ev = {~stage_blocked & blk_q, stage_blocked & ~blk_q, ~stage_trip & trip_q,
		stage_trip & ~trip_q, ~stage_start & start_q, stage_start & ~start_q};
	assign log_we   = new_ev[0] | new_ev[2] | new_ev[4];
	assign log_code = new_ev[4] ? EVT_BLOCK_ON : (new_ev[2] ? EVT_TRIP_ON : EVT_START_ON);

	always_comb begin
		emit_code = 3'h0;
		for (int i = 5; i >= 0; i--) begin
			if (pend[i]) begin
				emit_code = 3'(i);
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			start_q        <= 1'b0;
			trip_q         <= 1'b0;
			blk_q          <= 1'b0;
			pend           <= 6'h0;
			evt_valid      <= 1'b0;
			evt_code       <= 3'h0;
			evt_time       <= 64'h0;
			evt_value      <= 32'h0;
			evt_ratio      <= 32'h0;
			evt_fault_mode <= 3'h0;
			hmi_block_note <= 1'b0;
		end else begin
			start_q        <= stage_start;
			trip_q         <= stage_trip;
			blk_q          <= stage_blocked;
			hmi_block_note <= new_ev[4];
			evt_valid      <= |pend;
			// A new event wins over the clearing of the one being sent in the same clock.
			pend <= (pend & ~(6'h1 << emit_code)) | (new_ev & ctrl[CTRL_MASK_LO +: 6]);
			if (|pend) begin
				evt_code       <= emit_code;
				evt_time       <= rtc_time;
				evt_value      <= meas_s;
				evt_ratio      <= ratio;
				evt_fault_mode <= ctrl[2:0];
			end
		end
	end

	// Operation log: twelve newest ON records, the oldest overwritten first.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			log_wp  <= 4'h0;
			log_cnt <= 4'h0;
			for (int i = 0; i < LOG_DEPTH; i++) begin
				log_mem[i] <= '0;
			end
		end else if (log_we) begin
			log_mem[log_wp] <= '{rtc_time, log_code, setting_group, meas_s, ratio, remain};
			log_wp          <= (log_wp == 4'(LOG_DEPTH - 1)) ? 4'h0 : log_wp + 4'h1;
			if (log_cnt != 4'(LOG_DEPTH)) begin
				log_cnt <= log_cnt + 4'h1;
			end
		end
	end

	// ==========================================================================
	// AXI4-Lite write side: address and data are taken together, the response follows.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end else begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end else if (!s_axi_bvalid && !s_axi_awready && s_axi_awvalid && s_axi_wvalid) begin
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
			if (s_axi_awready) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_mapped(wa) ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// Settings registers; new values act from the next program cycle on.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl     <= {22'h0, EVT_MASK_RST, 1'b0, MODE_RST};
			pickup   <= PICKUP_RST;
			hyst     <= HYST_RST;
			op_steps <= OP_STEPS_RST;
			rl_steps <= RL_STEPS_RST;
			blk_lim  <= 32'sh0;
			log_sel  <= 4'h0;
		end else if (s_axi_awready) begin
			unique case (wa)
				OFS_CTRL:     ctrl     <= {22'h0, ctrl_wr[9:0]};
				OFS_PICKUP:   pickup   <= merge_strb(pickup, s_axi_wdata, s_axi_wstrb);
				OFS_HYST:     hyst     <= merge_strb(hyst, s_axi_wdata, s_axi_wstrb);
				OFS_OP_STEPS: op_steps <= merge_strb(op_steps, s_axi_wdata, s_axi_wstrb);
				OFS_RL_STEPS: rl_steps <= merge_strb(rl_steps, s_axi_wdata, s_axi_wstrb);
				OFS_BLK_LIM:  blk_lim  <= merge_strb(blk_lim, s_axi_wdata, s_axi_wstrb);
				OFS_LOG_SEL:  log_sel  <= s_axi_wstrb[0] ? s_axi_wdata[3:0] : log_sel;
				default: ;
			endcase
		end
	end

	// AXI4-Lite read side; log reads pick a record by age, zero being the newest.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			logic [4:0] idx;
			psc_rec_s   rec;
			idx = 5'(log_wp) + 5'(LOG_DEPTH - 1) - 5'(log_sel);
			idx = (idx >= 5'(LOG_DEPTH)) ? idx - 5'(LOG_DEPTH) : idx;
			rec = (log_sel < log_cnt) ? log_mem[4'(idx)] : '0;
			s_axi_arready <= 1'b0;
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end else if (!s_axi_rvalid && !s_axi_arready && s_axi_arvalid) begin
				s_axi_arready <= 1'b1;
			end
			if (s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= RESP_OKAY;
				unique case (ra)
					OFS_CTRL:     s_axi_rdata <= ctrl;
					OFS_PICKUP:   s_axi_rdata <= pickup;
					OFS_HYST:     s_axi_rdata <= hyst;
					OFS_OP_STEPS: s_axi_rdata <= op_steps;
					OFS_RL_STEPS: s_axi_rdata <= rl_steps;
					OFS_BLK_LIM:  s_axi_rdata <= blk_lim;
					OFS_STATUS:   s_axi_rdata <= {27'h0, stage_blocked, stage_trip, stage_start, stage_status};
					OFS_REMAIN:   s_axi_rdata <= remain;
					OFS_LOG_SEL:  s_axi_rdata <= {24'h0, log_cnt, log_sel};
					OFS_LOG_TSLO: s_axi_rdata <= rec.stamp[31:0];
					OFS_LOG_TSHI: s_axi_rdata <= rec.stamp[63:32];
					OFS_LOG_INFO: s_axi_rdata <= {24'h0, 1'b0, rec.group, 1'b0, rec.code};
					OFS_LOG_VAL:  s_axi_rdata <= rec.value;
					OFS_LOG_RAT:  s_axi_rdata <= rec.ratio;
					OFS_LOG_REM:  s_axi_rdata <= rec.remain;
					default: begin
						s_axi_rdata <= 32'h0;
						s_axi_rresp <= RESP_SLVERR;
					end
				endcase
			end
		end
	end

	// ==========================================================================
	// Checks.
	a_over_mode: assert property (@(posedge clk) disable iff (!reset_n)
		mode == MODE_OVER && !picked && meas_s > pickup |-> pu)
		else $error("over mode missed a pick-up");
	a_abs_over: assert property (@(posedge clk) disable iff (!reset_n)
		mode == MODE_OVER_ABS && !picked && meas_s < 0 && -64'(meas_s) > 64'(pickup) |-> pu)
		else $error("absolute over mode missed a pick-up");
	a_under_limit: assert property (@(posedge clk) disable iff (!reset_n)
		mode == MODE_UNDER && ctrl[CTRL_BLK_EN] && meas_s < blk_lim |-> !pu)
		else $error("under mode ignored the blocking limit");
	a_start_free: assert property (@(posedge clk) disable iff (!reset_n)
		eval && state == ST_IDLE && pu && !blk_s |=> stage_start && state == ST_START ##1 start_q)
		else $error("unblocked pick-up did not start");
	a_block_path: assert property (@(posedge clk) disable iff (!reset_n)
		eval && pu && blk_s |=> stage_blocked && !stage_start && stage_status == STAT_BLOCKED)
		else $error("blocked pick-up was not reported as blocked");
	a_trip_timer: assert property (@(posedge clk) disable iff (!reset_n)
		eval && state == ST_START && pu && !blk_s && op_cnt + 32'h1 >= op_lim |=> stage_trip)
		else $error("operate delay expired without trip");
	a_event_mask: assert property (@(posedge clk) disable iff (!reset_n)
		evt_valid |-> ctrl[CTRL_MASK_LO + 32'(evt_code)] && $past(pend[emit_code]) && $past(emit_code) == evt_code)
		else $error("masked or unqueued event was sent");
	a_log_on: assert property (@(posedge clk) disable iff (!reset_n)
		$rose(stage_start) && log_cnt != 4'(LOG_DEPTH) |=> log_cnt == $past(log_cnt) + 4'h1)
		else $error("start ON was not logged");
	a_block_note: assert property (@(posedge clk) disable iff (!reset_n)
		$rose(stage_blocked) |-> ##[1:2] hmi_block_note)
		else $error("blocking gave no notification");
	a_axi_resp: assert property (@(posedge clk) disable iff (!reset_n)
		s_axi_awready |=> s_axi_bvalid ##0 (s_axi_bresp == RESP_OKAY) == wr_mapped($past(wa)))
		else $error("write response missing or wrong");
endmodule

// ---- tb/psc_testbench.sv ----
// Self-checking testbench for the programmable stage comparator.
`timescale 1ns/10ps
module testbench;
	import psc_pkg::*;
	// ==========================================================================
	// Stimulus signals; a short program cycle keeps the delay timers quick.
	localparam int P = 10;
	logic              clk = 0, reset_n = 0, blk = 0, awv = 0, wv = 0, arv = 0;
	logic              awr, wrd, bv, arr, rv, st, tr, bl;
	logic [7:0]        awa = 0, ara = 0;
	logic [31:0]       wd = 0, rdat, d;
	logic [1:0]        bresp, rresp, r, stat;
	logic signed [31:0] meas = 0;
	logic [63:0]       rtc = 0;
	int                errors = 0, n_tests = 0;
	logic              ev_v, note;
	logic [2:0]        ev_c, ev_md, ev_fm;
	logic [63:0]       ev_t, ev_f;
	logic [31:0]       ev_val, ev_rat;
	logic [3:0]        n_ev [6] = '{default: 4'h0};
	int                n_note = 0;
	logic [7:0]        ofs [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
	logic [31:0]       rst_v [6] = '{32'h3f0, 32'h64, 32'h7530, 32'h8, 32'hc, 32'h0};

	always #50 clk = ~clk;
	always @(posedge clk) rtc <= rtc + 64'h1;

	psc_stage #(.PROG_CLKS(P)) DUT (
		.clk(clk), .reset_n(reset_n), .meas_value(meas), .block_in(blk), .setting_group(3'h2),
		.rtc_time(rtc), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd),
		.s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(1'b1), .s_axi_araddr(ara),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
		.s_axi_rvalid(rv), .s_axi_rready(1'b1), .stage_start(st), .stage_trip(tr),
		.stage_blocked(bl), .stage_status(stat), .evt_valid(ev_v), .evt_code(ev_c), .evt_time(ev_t),
		.evt_value(ev_val), .evt_ratio(ev_rat), .evt_fault_mode(ev_md), .hmi_block_note(note));

	// ==========================================================================
	// Helpers. Outputs are sampled on the falling edge, where registered values are settled.
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic ta, tw, tb;
		awa <= a;
		wd <= v;
		awv <= 1'b1;
		wv <= 1'b1;
		do begin
			@(negedge clk);
			ta = awr; tw = wrd; tb = bv; r = bresp;
			@(posedge clk);
			if (ta) awv <= 1'b0;
			if (tw) wv <= 1'b0;
		end while (!tb);
	endtask
	task automatic rd(input logic [7:0] a);
		logic ta, tv;
		ara <= a;
		arv <= 1'b1;
		do begin
			@(negedge clk);
			ta = arr; tv = rv; d = rdat; r = rresp;
			@(posedge clk);
			if (ta) arv <= 1'b0;
		end while (!tv);
	endtask
	// Waits n program cycles, then compares start, trip, blocked and status under a mask.
	task automatic look(input int n, input logic [4:0] e, input logic [4:0] m = 5'h1f);
		repeat (n * P) @(posedge clk);
		@(negedge clk);
		chk({st, tr, bl, stat} & m, e);
		@(posedge clk);
	endtask
	// Event watcher: counts sends per code, keeps the last payload and checks every stamp.
	always @(negedge clk) begin
		if (ev_v) begin
			n_ev[ev_c] <= n_ev[ev_c] + 4'h1;
			ev_f       <= {ev_val, ev_rat};
			ev_fm      <= ev_md;
			chk(ev_t, rtc - 64'h1);
		end
		if (note) begin
			n_note <= n_note + 1;
		end
	end
	task automatic give_verdict();
		if (errors == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	// ==========================================================================
	// Main sequence: registers, refusals, then the over, under, signed change and absolute over modes in turn.
	initial begin
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 6; i++) begin
			rd(ofs[i]);
			chk({d, r}, {rst_v[i], 2'h0});
		end
		rd(8'h3c);
		chk({d, r}, {32'h0, 2'h2});
		wr(8'h18, 32'h1);
		chk(r, 2'h2);
		wr(8'h04, 32'd1000);
		meas <= 2000;
		look(3, 5'b10001);
		chk(ev_f, {32'd2000, 32'd2000});
		look(30, 5'b00001, 5'b01111);
		look(15, 5'b01010, 5'b01111);
		blk <= 1'b1;
		look(3, 5'b01100, 5'b11100);
		look(70, 5'b00111);
		blk <= 1'b0;
		meas <= 0;
		look(3, 5'b00000);
		chk({n_ev[5], n_ev[4], n_ev[3], n_ev[2], n_ev[1], n_ev[0]}, 24'h111111);
		wr(8'h14, 32'd800);
		// Under mode with the limit on and START OFF masked out of the event stream.
		wr(8'h00, 32'h3da);
		meas <= 500;
		look(5, 5'b00000);
		meas <= 900;
		look(3, 5'b10001);
		meas <= 1020;
		look(3, 5'b10001);
		meas <= 1500;
		look(80, 5'b00000);
		chk({n_ev[1], n_ev[0]}, 8'h12);
		// Signed change mode: a rise beyond pick-up starts, a fall of the same size does not.
		wr(8'h00, 32'h3f6);
		meas <= 3000;
		look(3, 5'b10001);
		meas <= 1500;
		look(70, 5'b00000);
		meas <= -2000;
		wr(8'h00, 32'h3f1);
		look(3, 5'b10001);
		// Blocking arrives well before the operate delay runs out, so no trip may follow.
		blk <= 1'b1;
		look(3, 5'b00111);
		look(50, 5'b00111);
		chk({n_ev[5], n_ev[4], n_ev[3], n_ev[2], n_ev[1], n_ev[0]}, 24'h121134);
		chk(n_note, 2);
		chk(ev_fm, 3'h1);
		chk(ev_f, {32'hfffff830, 32'hfffff830});
		rd(8'h20);
		chk({d, r}, {32'h70, 2'h0});
		rd(8'h2c);
		chk(d, 32'h24);
		rd(8'h30);
		chk(d, 32'hfffff830);
		give_verdict();
	end

	// A hang ends the run as a failure well after the sequence should be done.
	initial begin
		repeat (4000 * P) @(posedge clk);
		errors++;
		give_verdict();
	end
endmodule
